// ==== rtl/timer_clock_select.sv ====
// Count-clock selection for two timer channels with event input
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module timer_clock_select (
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic [tmr_clk_pkg::ADDR_W-1:0] bus_addr_in,
  input  wire logic [3:0]              bus_wdata_in,
  input  wire logic                    bus_wr_in,
  input  wire logic                    bus_rd_in,
  input  wire logic                    low_speed_osc_in,
  input  wire logic                    high_speed_osc_in,
  input  wire logic                    event_input_pin_in,
  output logic [3:0]                   bus_rdata_out,
  output logic                         ch0_count_tick_out,
  output logic                         ch1_count_tick_out,
  output tmr_clk_pkg::ctrl_s           ctrl_out
);
  import tmr_clk_pkg::*;

  typedef struct packed {
    ctrl_s      ctrl;
    logic [3:0] rdata;
    logic [3:0] filt_cnt;
    logic       filt_level;
    logic [1:0] filt_falls;
    logic       ev_tick;
    logic       ch0_tick;
    logic       ch1_tick;
  } top_s;

  top_s             st_reg;
  top_s             st_next;
  bus_req_s         req;
  logic [15:0]      idx;
  logic             lo_lvl;
  logic             lo_rise;
  logic             lo_fall;
  logic             hi_rise;
  logic             pin_lvl;
  logic             pin_rise;
  logic             pin_fall;
  logic             src0_tick;
  logic             src1_tick;
  logic             pre0_tick;
  logic             pre1_tick;
  logic             fclk_fall;
  logic             raw_edge;

  assign req = '{addr: bus_addr_in, wdata: bus_wdata_in, wr: bus_wr_in, rd: bus_rd_in};
  assign idx = req.addr[ADDR_W-1:2];

  // Oscillator and pin synchronisers
  edge_sync u_lo (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (low_speed_osc_in),
    .level_out  (lo_lvl),
    .rise_out   (lo_rise),
    .fall_out   (lo_fall)
  );

  edge_sync u_hi (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (high_speed_osc_in),
    .level_out  (),
    .rise_out   (hi_rise),
    .fall_out   ()
  );

  edge_sync u_pin (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (event_input_pin_in),
    .level_out  (pin_lvl),
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  assign src0_tick = st_reg.ctrl.ch0_source_select ? hi_rise : lo_rise;
  assign src1_tick = st_reg.ctrl.ch1_source_select ? hi_rise : lo_rise;

  ratio_prescaler #(.CNT_W(8)) u_pre0 (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .src_tick_in (src0_tick),
    .ratio_in    (st_reg.ctrl.ch0_ratio),
    .tick_out    (pre0_tick)
  );

  ratio_prescaler #(.CNT_W(8)) u_pre1 (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .src_tick_in (src1_tick),
    .ratio_in    (st_reg.ctrl.ch1_ratio),
    .tick_out    (pre1_tick)
  );

  // Filter sample clock falls once per FILT_DIV low-speed cycles
  assign fclk_fall = lo_fall & (st_reg.filt_cnt == 4'(FILT_DIV - 1));

  assign raw_edge = st_reg.ctrl.event_edge_polarity ? pin_rise : pin_fall;

  // Next state: bus, filter, tick selection
  always_comb begin
    st_next          = st_reg;
    st_next.rdata    = '0;
    st_next.ev_tick  = 1'b0;
    if (lo_fall) begin
      st_next.filt_cnt = st_reg.filt_cnt + 4'h1;
    end
    if (req.wr) begin
      unique case (idx)
        MODE_CTRL_IDX: begin
          st_next.ctrl.event_edge_polarity = req.wdata[POL_BIT];
          st_next.ctrl.noise_filter_enable = req.wdata[FILT_BIT];
          st_next.ctrl.ch0_event_mode      = req.wdata[EVMODE_BIT];
        end
        SRC_CTRL_IDX: begin
          st_next.ctrl.ch0_source_select = req.wdata[SRC0_BIT];
          st_next.ctrl.ch1_source_select = req.wdata[SRC1_BIT];
        end
        DIV0_CTRL_IDX: st_next.ctrl.ch0_ratio = req.wdata[RATIO_LSB +: 2];
        DIV1_CTRL_IDX: st_next.ctrl.ch1_ratio = req.wdata[RATIO_LSB +: 2];
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (idx)
        MODE_CTRL_IDX: st_next.rdata = {1'b0, st_reg.ctrl.ch0_event_mode,
                                        st_reg.ctrl.noise_filter_enable, st_reg.ctrl.event_edge_polarity};
        SRC_CTRL_IDX:  st_next.rdata = {2'b00, st_reg.ctrl.ch1_source_select, st_reg.ctrl.ch0_source_select};
        DIV0_CTRL_IDX: st_next.rdata = {st_reg.ctrl.ch0_ratio, 2'b00};
        DIV1_CTRL_IDX: st_next.rdata = {st_reg.ctrl.ch1_ratio, 2'b00};
        default:       st_next.rdata = '0;
      endcase
    end
    // level change accepted at second sample fall
    if (pin_lvl == st_reg.filt_level) begin
      st_next.filt_falls = 2'h0;
    end else if (fclk_fall) begin
      if (st_reg.filt_falls == 2'h1) begin
        st_next.filt_level = pin_lvl;
        st_next.filt_falls = 2'h0;
        st_next.ev_tick    = st_reg.ctrl.event_edge_polarity ? pin_lvl : ~pin_lvl;
      end else begin
        st_next.filt_falls = st_reg.filt_falls + 2'h1;
      end
    end
    // filter choice only in event mode
    if (!st_reg.ctrl.noise_filter_enable) begin
      st_next.ev_tick = raw_edge;
    end
    // mode bit picks event or prescaler
    // source bit unused in event mode
    st_next.ch0_tick = st_reg.ctrl.ch0_event_mode ? st_reg.ev_tick : pre0_tick;
    st_next.ch1_tick = pre1_tick;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg            <= '0;
      st_reg.ctrl       <= '0;
      st_reg.filt_level <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // downstream counters decrement on these ticks
  assign ch0_count_tick_out = st_reg.ch0_tick;
  assign ch1_count_tick_out = st_reg.ch1_tick;
  assign bus_rdata_out      = st_reg.rdata;
  assign ctrl_out           = st_reg.ctrl;
endmodule

// ==== pkg/tmr_clk_pkg.sv ====
// Constants and carrier types for the timer count-clock front end
package tmr_clk_pkg;

  // Register indices; the bus byte address is 4 * index so every register sits on a word
  localparam logic [15:0] MODE_CTRL_IDX   = 16'hFFC0;
  localparam logic [15:0] SRC_CTRL_IDX    = 16'hFFC1;
  localparam logic [15:0] DIV0_CTRL_IDX   = 16'hFFC2;
  localparam logic [15:0] DIV1_CTRL_IDX   = 16'hFFC3;
  localparam int          ADDR_W          = 18;

  // Field positions
  localparam int POL_BIT     = 0;
  localparam int FILT_BIT    = 1;
  localparam int EVMODE_BIT  = 2;
  localparam int SRC0_BIT    = 0;
  localparam int SRC1_BIT    = 1;
  localparam int RATIO_LSB   = 2;

  // Reset values
  localparam logic [3:0] MODE_RST  = 4'h0;
  localparam logic [3:0] SRC_RST   = 4'h0;
  localparam logic [3:0] DIV_RST   = 4'h0;

  // Ratio codes and division counts
  localparam logic [1:0] RATIO_1   = 2'h0;
  localparam logic [1:0] RATIO_4   = 2'h1;
  localparam logic [1:0] RATIO_32  = 2'h2;
  localparam logic [1:0] RATIO_256 = 2'h3;
  localparam int DIV_4   = 4;
  localparam int DIV_32  = 32;
  localparam int DIV_256 = 256;

  // Noise rejecter sample rate and its low-speed source
  localparam int FILT_HZ    = 2048;
  localparam int LOW_OSC_HZ = 32768;
  localparam int FILT_DIV   = LOW_OSC_HZ / FILT_HZ;

  // Software control fields
  typedef struct packed {
    logic       ch0_event_mode;
    logic       noise_filter_enable;
    logic       event_edge_polarity;
    logic       ch0_source_select;
    logic       ch1_source_select;
    logic [1:0] ch0_ratio;
    logic [1:0] ch1_ratio;
  } ctrl_s;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0]        wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

endpackage

// ==== rtl/edge_sync.sv ====
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
module edge_sync (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // Shift chain; first stage feeds only the second
  always_comb begin
    st_next      = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.sync;
  assign rise_out  = st_reg.sync & ~st_reg.prev;
  assign fall_out  = ~st_reg.sync & st_reg.prev;
endmodule

// ==== rtl/ratio_prescaler.sv ====
// Prescaler: divides source tick stream by 1, 4, 32 or 256
`timescale 1ns/1ns
module ratio_prescaler #(
  parameter int CNT_W = 8
) (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       src_tick_in,
  input  wire logic [1:0] ratio_in,
  output logic            tick_out
);
  import tmr_clk_pkg::*;

  // Counter must hold the largest terminal count
  if (CNT_W < 8) begin : g_cnt_w_check
    $error("CNT_W too small for divide by 256");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } pre_s;

  pre_s             st_reg;
  pre_s             st_next;
  logic [CNT_W-1:0] last;

  // Terminal count for the selected ratio
  always_comb begin
    unique case (ratio_in)
      RATIO_256: last = CNT_W'(DIV_256 - 1);
      RATIO_32:  last = CNT_W'(DIV_32 - 1);
      RATIO_4:   last = CNT_W'(DIV_4 - 1);
      RATIO_1:   last = '0;
    endcase
  end

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (src_tick_in) begin
      if (st_reg.cnt >= last) begin
        st_next.cnt  = '0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;
endmodule

// ==== verification/clock_select_properties.sv ====
// Checker for the timer count-clock front end
`timescale 1ns/1ns
module clock_select_checker (
  input wire logic                           clk_in,
  input wire logic                           sys_rst_in,
  input wire logic [tmr_clk_pkg::ADDR_W-1:0] bus_addr_in,
  input wire logic [3:0]                     bus_wdata_in,
  input wire logic                           bus_wr_in,
  input wire logic                           bus_rd_in,
  input wire logic                           low_speed_osc_in,
  input wire logic                           high_speed_osc_in,
  input wire logic                           event_input_pin_in,
  input wire logic [3:0]                     bus_rdata_out,
  input wire logic                           ch0_count_tick_out,
  input wire logic                           ch1_count_tick_out,
  input wire tmr_clk_pkg::ctrl_s             ctrl_out
);
  import tmr_clk_pkg::*;
  localparam logic [ADDR_W-1:0] A_MODE = {MODE_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_SRC  = {SRC_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_DIV0 = {DIV0_CTRL_IDX, 2'h0};
  logic [3:0] quiet_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Cycles since any source, pin or setting last changed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !$stable(low_speed_osc_in) || !$stable(high_speed_osc_in)
        || !$stable(event_input_pin_in) || !$stable(ctrl_out))
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
  end
  sequence s_mode_wr;
    bus_wr_in && bus_addr_in == A_MODE;
  endsequence
  sequence s_mode_rd;
    bus_rd_in && bus_addr_in == A_MODE;
  endsequence
  rst_clears_ctrl_a:
    assert property ($past(sys_rst_in) |-> ctrl_out == ctrl_s'(0)) else $error("fields not cleared");
  mode_write_a:
    assert property (s_mode_wr |=> ctrl_out.ch0_event_mode == $past(bus_wdata_in[EVMODE_BIT])
      && ctrl_out.noise_filter_enable == $past(bus_wdata_in[FILT_BIT])
      && ctrl_out.event_edge_polarity == $past(bus_wdata_in[POL_BIT])) else $error("mode write lost");
  src_write_a:
    assert property (bus_wr_in && bus_addr_in == A_SRC |=> ctrl_out.ch0_source_select == $past(bus_wdata_in[0])
      && ctrl_out.ch1_source_select == $past(bus_wdata_in[1])) else $error("source write lost");
  ratio_write_a:
    assert property (bus_wr_in && bus_addr_in == A_DIV0 |=> ctrl_out.ch0_ratio == $past(bus_wdata_in[3:2]))
      else $error("ratio write lost");
  mode_readback_a:
    assert property (s_mode_rd |=> bus_rdata_out == {1'b0, $past(ctrl_out.ch0_event_mode),
      $past(ctrl_out.noise_filter_enable), $past(ctrl_out.event_edge_polarity)}) else $error("bad readback");
  rdata_idle_a:
    assert property (!$past(bus_rd_in) |-> bus_rdata_out == 4'h0) else $error("read data not idle");
  tick_pulse_a:
    assert property (ch0_count_tick_out |=> !ch0_count_tick_out) else $error("tick longer than a cycle");
  no_cause_tick_a:
    assert property (quiet_reg >= 4'hC |-> !ch0_count_tick_out && !ch1_count_tick_out)
      else $error("tick without cause");
endmodule
bind timer_clock_select clock_select_checker chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
  .low_speed_osc_in(low_speed_osc_in), .high_speed_osc_in(high_speed_osc_in),
  .event_input_pin_in(event_input_pin_in), .bus_rdata_out(bus_rdata_out),
  .ch0_count_tick_out(ch0_count_tick_out), .ch1_count_tick_out(ch1_count_tick_out), .ctrl_out(ctrl_out));

// ==== verification/event_pulse_source.sv ====
// External event source driving the event input pin
`timescale 1ns/1ns
module event_pulse_source (
  input  wire logic clk_in,
  output logic      event_input_pin_out
);
  initial event_input_pin_out = 1'b0;
  // Pin level changes just after a clock edge and then holds
  task automatic drive(input logic v);
    @(posedge clk_in);
    event_input_pin_out <= v;
  endtask
endmodule

// ==== verification/timer_clock_select_bench.sv ====
// Testbench for the timer count-clock front end
`timescale 1ns/1ns
module timer_clock_select_bench;
  import tmr_clk_pkg::*;
  logic              clk_in, sys_rst_in, wr, rd, lo, hi, lo_run, hi_run, ph;
  logic [ADDR_W-1:0] addr;
  logic [3:0]        wdata, rdata;
  logic              pin, ch0, ch1;
  logic [15:0]       n0, n1;
  ctrl_s             ctrl;
  int                fail_count = 0, compares = 0;
  timer_clock_select dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_rd_in(rd), .low_speed_osc_in(lo), .high_speed_osc_in(hi), .event_input_pin_in(pin),
    .bus_rdata_out(rdata), .ch0_count_tick_out(ch0), .ch1_count_tick_out(ch1), .ctrl_out(ctrl));
  event_pulse_source ev_u (.clk_in(clk_in), .event_input_pin_out(pin));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Oscillators toggle every two cycles while enabled; ticks are counted
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ph <= 1'b0;
      lo <= 1'b0;
      hi <= 1'b0;
      n0 <= '0;
      n1 <= '0;
    end else begin
      ph <= ~ph;
      if (ph && lo_run) lo <= ~lo;
      if (ph && hi_run) hi <= ~hi;
      n0 <= n0 + 16'(ch0);
      n1 <= n1 + 16'(ch1);
    end
  end
  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] a, b, seen);
    compares++;
    if ((seen >= a && seen <= b) !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, a, b, seen);
    end
  endtask
  task automatic wr_reg(input logic [15:0] idx, input logic [3:0] d);
    @(posedge clk_in);
    addr <= {idx, 2'h0};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] idx, input logic [3:0] e);
    @(posedge clk_in);
    addr <= {idx, 2'h0};
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk("rdata", 16'(e), 16'(e), 16'(rdata));
  endtask
  // Ticks on both channels over a window must fall in the given ranges
  task automatic win(input int cyc, input logic [15:0] a0, b0, a1, b1);
    logic [15:0] s0, s1;
    s0 = n0;
    s1 = n1;
    repeat (cyc) @(posedge clk_in);
    #1 chk("ch0_ticks", a0, b0, n0 - s0);
    chk("ch1_ticks", a1, b1, n1 - s1);
  endtask
  task automatic osc(input logic l, h);
    @(posedge clk_in);
    lo_run <= l;
    hi_run <= h;
    repeat (12) @(posedge clk_in);
  endtask
  task automatic t_regs;
    logic [15:0] idx [4] = '{MODE_CTRL_IDX, SRC_CTRL_IDX, DIV0_CTRL_IDX, DIV1_CTRL_IDX};
    logic [3:0]  msk [4] = '{4'h7, 4'h3, 4'hC, 4'hC};
    for (int i = 0; i < 4; i++) rd_reg(idx[i], 4'h0);
    chk("ctrl_out", 16'h0000, 16'h0000, 16'(ctrl));
    for (int i = 0; i < 4; i++) wr_reg(idx[i], 4'hF);
    for (int i = 0; i < 4; i++) rd_reg(idx[i], msk[i]);
    chk("ctrl_out", 16'h01FF, 16'h01FF, 16'(ctrl));
    rd_reg(16'h0010, 4'h0);
    for (int i = 0; i < 4; i++) wr_reg(idx[i], 4'h0);
  endtask
  task automatic t_ratio;
    int dv [4] = '{1, 4, 32, 256};
    osc(1'b1, 1'b0);
    for (int r = 0; r < 4; r++) begin
      wr_reg(DIV0_CTRL_IDX, 4'(r << 2));
      wr_reg(DIV1_CTRL_IDX, 4'(r << 2));
      repeat (12) @(posedge clk_in);
      win(16 * dv[r], 3, 5, 3, 5);
    end
  endtask
  task automatic t_source;
    wr_reg(DIV0_CTRL_IDX, 4'h0);
    wr_reg(DIV1_CTRL_IDX, 4'h0);
    wr_reg(SRC_CTRL_IDX, 4'h2);
    osc(1'b1, 1'b0);
    win(64, 15, 17, 0, 0);
    osc(1'b0, 1'b1);
    win(64, 0, 0, 15, 17);
  endtask
  task automatic t_event;
    wr_reg(SRC_CTRL_IDX, 4'h1);
    wr_reg(DIV0_CTRL_IDX, 4'hC);
    wr_reg(MODE_CTRL_IDX, 4'h4);
    osc(1'b1, 1'b1);
    win(64, 0, 0, 15, 17);
    ev_u.drive(1'b1);
    win(16, 0, 0, 3, 5);
    ev_u.drive(1'b0);
    win(16, 1, 1, 3, 5);
    wr_reg(MODE_CTRL_IDX, 4'h5);
    repeat (12) @(posedge clk_in);
    ev_u.drive(1'b1);
    win(16, 1, 1, 3, 5);
    ev_u.drive(1'b0);
    win(16, 0, 0, 3, 5);
  endtask
  task automatic t_filter;
    wr_reg(MODE_CTRL_IDX, 4'h7);
    repeat (12) @(posedge clk_in);
    ev_u.drive(1'b1);
    win(56, 0, 0, 13, 15);
    ev_u.drive(1'b0);
    win(200, 0, 0, 49, 51);
    ev_u.drive(1'b1);
    win(200, 1, 1, 49, 51);
    ev_u.drive(1'b0);
    win(200, 0, 0, 49, 51);
  endtask
  task automatic t_timer_pin;
    osc(1'b0, 1'b0);
    wr_reg(MODE_CTRL_IDX, 4'h3);
    repeat (12) @(posedge clk_in);
    ev_u.drive(1'b1);
    win(20, 0, 0, 0, 0);
    ev_u.drive(1'b0);
    win(20, 0, 0, 0, 0);
  endtask
  // Reset, then every scenario in turn
  initial begin
    sys_rst_in <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= '0;
    wdata <= '0;
    lo_run <= 1'b0;
    hi_run <= 1'b0;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_ratio();
    t_source();
    t_event();
    t_filter();
    t_timer_pin();
    report_and_stop();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_in);
    fail_count++;
    report_and_stop();
  end
endmodule
